/* rtl/fisi_map.svh */
// fisi_map.svh: register offsets, field positions, reset values and
// timing figures of the fault input and status indicator block.
// assumes: included by its bare name from the package and the modules.
`ifndef FISI_MAP_SVH
`define FISI_MAP_SVH

// apb address width and register byte offsets
`define FISI_ADDR_W 8
`define FISI_OFS_CTRL 8'h00
`define FISI_OFS_NODE 8'h04
`define FISI_OFS_STAT 8'h08

// control register fields
`define FISI_CTRL_W 5
`define FISI_CTRL_RST 5'h00
`define FISI_NODE_W 5
`define FISI_NODE_RST 5'h00
`define FISI_NODE_ZERO 5'h00

// status register bit positions
`define FISI_ST_FLT 0
`define FISI_ST_PF 1
`define FISI_ST_SER 2
`define FISI_ST_XBLK 3
`define FISI_ST_IND1 4
`define FISI_ST_IND2 5
`define FISI_ST_INIT 6
`define FISI_ST_W 7

// timing figures, clock in MHz, times in microseconds, stream stable count in cycles
`define FISI_CLK_MHZ 50
`define FISI_PF_QUAL_US 700
`define FISI_DSR_LOW_US 44
`define FISI_BLINK_HALF_US 250000
`define FISI_DISTORT_US 40
`define FISI_MAN_STABLE 3

`endif

/* rtl/fisi_pkg.sv */
// fisi_pkg.sv: types shared by the fault input and indicator modules.
// assumes: fisi_map.svh sits on the include path.
`include "fisi_map.svh"

package fisi_pkg;

    // operating mode of the device
    typedef enum logic [1:0] {
        FISI_SLAVE,
        FISI_MASTER,
        FISI_REPEATER,
        FISI_MONITOR
    } fisi_mode_e;

    // control register layout, msb first
    typedef struct packed {
        logic dual;
        logic ext;
        logic pol;
        fisi_mode_e mode;
    } fisi_ctrl_s;

    // lamp request, one means the lamp is lit
    typedef struct packed {
        logic red;
        logic green;
    } fisi_lamp_s;

endpackage : fisi_pkg

/* rtl/fisi_sync.sv */
// fisi_sync.sv: two flip-flop level synchroniser.
// assumes: one clock, asynchronous active low reset.
`timescale 1ns/10ps
`default_nettype none

module fisi_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : fisi_sync

`default_nettype wire

/* rtl/fisi_qual.sv */
// fisi_qual.sv: qualifies a level held for a run of consecutive cycles.
// assumes: one clock, asynchronous active low reset.
`timescale 1ns/10ps
`default_nettype none

module fisi_qual #(
    parameter int CNT = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level to qualify and qualified result
    input wire logic en,
    output logic done
);

    localparam int CW = $clog2(CNT + 1);
    localparam logic [CW-1:0] LAST = CW'(CNT - 1);

    logic [CW-1:0] cnt_r;

    // counter restarts from zero whenever the level drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (!en) begin
            cnt_r <= '0;
            done <= 1'b0;
        end else if (!done) begin
            cnt_r <= cnt_r + CW'(1);
            done <= (cnt_r == LAST);
        end
    end

endmodule : fisi_qual

`default_nettype wire

/* rtl/fisi_top.sv */
// fisi_top.sv: fault input, power fail and indicator output logic with
// an apb register slave.
// assumes: all pin inputs synchronous to REF_CLK at 50 MHz; the pads
// resolve the open-drain indicator pins from the output enables.
`timescale 1ns/10ps
`default_nettype none

`include "fisi_map.svh"

// Functional notes
// - slave mode: fault input drives status bit
// - polarity clear: high input means fault
// - polarity set: invert input before everything
// - fault input synchronised before status bit
// - power fail after 0.7 ms low
// - no power fail during initialisation
// - second indicator off unless ext/dual
// - dual lamp uses combined colour patterns
// - communication established shows steady green
// - blocked, monitor or watchdog: no-exchange pattern
// - extended, address zero: awaiting-address pattern
// - periphery fault: red flashes; dual lamp alternates green and red
// - strobe low over 44 us: serious
// - flashing patterns toggle near 2 Hz
// - addressing channel overrides first indicator
// - dual lamp: second off during addressing
// - other modes: first indicator carries stream
// - data inputs equal: active high stream
// - remove jitter from forwarded stream
// - failed telegram distorts forwarded stream
// - other modes: second indicator released
// - exchange block set by reset, cleared
// - strobe still low after init: serious
module fisi_top
    import fisi_pkg::*;
#(
    parameter int PF_QUAL_CYC = `FISI_PF_QUAL_US * `FISI_CLK_MHZ,
    parameter int BLINK_HALF_CYC = `FISI_BLINK_HALF_US * `FISI_CLK_MHZ
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`FISI_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // fault, power fail and strobe pins
    input wire logic FAULT_INDICATION_INPUT,
    input wire logic PF_COMPARATOR_LOW,
    input wire logic DATA_STROBE_N,
    input wire logic DATA_INPUT_TWO,
    input wire logic DATA_INPUT_THREE,
    // device core events and state
    input wire logic INIT_BUSY,
    input wire logic PARAM_WRITE_CALL,
    input wire logic COMM_NO_EXCHANGE,
    input wire logic WDOG_RESET_SEEN,
    input wire logic ADDR_CH_ACTIVE,
    input wire logic ADDR_CH_TX,
    input wire logic MAN_STREAM_IN,
    input wire logic TELEGRAM_ERROR,
    // status results
    output logic PERIPHERY_FAULT_STATUS_BIT,
    output logic POWER_FAIL_PARAMETER_PIN,
    output logic EXCHANGE_BLOCK,
    // first indicator, open drain
    input wire logic FIRST_INDICATOR_PIN,
    output logic FIRST_INDICATOR_DRIVE,
    output logic FIRST_INDICATOR_OE,
    // second indicator, open drain
    input wire logic SECOND_INDICATOR_PIN,
    output logic SECOND_INDICATOR_DRIVE,
    output logic SECOND_INDICATOR_OE
);

    localparam int DSR_CYC = `FISI_DSR_LOW_US * `FISI_CLK_MHZ;
    localparam int DIST_CYC = `FISI_DISTORT_US * `FISI_CLK_MHZ;
    localparam int BW = $clog2(BLINK_HALF_CYC + 1);
    localparam int DW = $clog2(DIST_CYC + 1);
    localparam int MW = $clog2(`FISI_MAN_STABLE + 1);
    localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_HALF_CYC - 1);
    localparam logic [DW-1:0] DIST_LOAD = DW'(DIST_CYC);
    localparam logic [MW-1:0] MAN_LAST = MW'(`FISI_MAN_STABLE - 1);

    // registers
    fisi_ctrl_s ctrl_r;
    logic [`FISI_NODE_W-1:0] node_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic flt_r;
    logic pf_r;
    logic ser_r;
    logic xblk_r;
    logic ind1_oe_r;
    logic ind2_oe_r;
    logic [BW-1:0] blink_cnt_r;
    logic phase_r;
    logic man_cand_r;
    logic [MW-1:0] man_cnt_r;
    logic man_q_r;
    logic [DW-1:0] dist_cnt_r;

    // wires
    logic flt_proc;
    logic flt_sync;
    logic pf_done;
    logic dsr_done;
    fisi_lamp_s lamp;

    // apb decode
    wire apb_setup = PSEL & ~PENABLE;
    wire apb_access = PSEL & PENABLE & pready_r;
    wire apb_wr = apb_access & PWRITE;
    wire hit_ctrl = (PADDR == `FISI_OFS_CTRL);
    wire hit_node = (PADDR == `FISI_OFS_NODE);
    wire hit_stat = (PADDR == `FISI_OFS_STAT);
    wire mapped = hit_ctrl | hit_node | hit_stat;

    // mode decode
    wire is_slave = (ctrl_r.mode == FISI_SLAVE);
    wire pf_mode = (ctrl_r.mode == FISI_MASTER) |
        (ctrl_r.mode == FISI_MONITOR);

    // status word
    logic [`FISI_ST_W-1:0] stat_w;
    always_comb begin
        stat_w = '0;
        stat_w[`FISI_ST_FLT] = flt_r;
        stat_w[`FISI_ST_PF] = pf_r;
        stat_w[`FISI_ST_SER] = ser_r;
        stat_w[`FISI_ST_XBLK] = xblk_r;
        stat_w[`FISI_ST_IND1] = FIRST_INDICATOR_PIN;
        stat_w[`FISI_ST_IND2] = SECOND_INDICATOR_PIN;
        stat_w[`FISI_ST_INIT] = INIT_BUSY;
    end

    // read data selection
    wire [31:0] rd_mux = hit_ctrl ?
        {{(32-`FISI_CTRL_W){1'b0}}, ctrl_r} :
        hit_node ? {{(32-`FISI_NODE_W){1'b0}}, node_r} :
        hit_stat ? {{(32-`FISI_ST_W){1'b0}}, stat_w} : 32'h0000_0000;

    // apb answer: ready in the first access cycle
    // read data is captured at setup and stands through the access
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup & ~mapped;
            prdata_r <= (apb_setup & ~PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // writable control registers
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_r <= fisi_ctrl_s'(`FISI_CTRL_RST);
            node_r <= `FISI_NODE_RST;
        end else begin
            if (apb_wr & hit_ctrl)
                ctrl_r <= fisi_ctrl_s'(PWDATA[`FISI_CTRL_W-1:0]);
            if (apb_wr & hit_node)
                node_r <= PWDATA[`FISI_NODE_W-1:0];
        end
    end

    // fault input: polarity first, then synchroniser
    assign flt_proc = FAULT_INDICATION_INPUT ^ ctrl_r.pol;

    fisi_sync #(
        .W(1)
    ) u_flt_sync (
        .clk(REF_CLK),
        .rst_n(NRST),
        .d(flt_proc),
        .q(flt_sync)
    );

    // power fail qualification, restarts on recovery or init
    // a change to slave or repeater mode also restarts it; master to monitor keeps the count
    fisi_qual #(
        .CNT(PF_QUAL_CYC)
    ) u_pf_qual (
        .clk(REF_CLK),
        .rst_n(NRST),
        .en(PF_COMPARATOR_LOW & pf_mode & ~INIT_BUSY),
        .done(pf_done)
    );

    // strobe low time qualification
    fisi_qual #(
        .CNT(DSR_CYC)
    ) u_dsr_qual (
        .clk(REF_CLK),
        .rst_n(NRST),
        .en(~DATA_STROBE_N),
        .done(dsr_done)
    );

    // status flags
    // serious fault is held back until initialisation is over
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            flt_r <= 1'b0;
            pf_r <= 1'b0;
            ser_r <= 1'b0;
        end else begin
            flt_r <= flt_sync & is_slave;
            pf_r <= pf_done & pf_mode & ~INIT_BUSY;
            ser_r <= dsr_done & ~INIT_BUSY & is_slave;
        end
    end

    // exchange block: only reset sets it, first parameter write clears
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST)
            xblk_r <= 1'b1;
        else if (PARAM_WRITE_CALL)
            xblk_r <= 1'b0;
    end

    // flash phase generator
    // one free-running phase keeps every flashing pattern in step
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            blink_cnt_r <= '0;
            phase_r <= 1'b0;
        end else if (blink_cnt_r == BLINK_LAST) begin
            blink_cnt_r <= '0;
            phase_r <= ~phase_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + BW'(1);
        end
    end

    // slave indication pattern, highest priority first
    wire no_exch = xblk_r | COMM_NO_EXCHANGE | WDOG_RESET_SEEN;
    wire addr0 = ctrl_r.ext & (node_r == `FISI_NODE_ZERO);
    always_comb begin
        lamp = '{red: 1'b0, green: 1'b1};
        if (ser_r) begin
            if (ctrl_r.dual)
                lamp = '{red: phase_r, green: 1'b0};
            else
                lamp = '{red: 1'b1, green: phase_r};
        end else if (flt_r) begin
            if (ctrl_r.dual)
                lamp = '{red: phase_r, green: ~phase_r};
            else
                lamp = '{red: phase_r, green: 1'b1};
        end else if (addr0) begin
            if (ctrl_r.dual)
                lamp = '{red: 1'b1, green: phase_r};
            else
                lamp = '{red: phase_r, green: 1'b0};
        end else if (no_exch) begin
            if (ctrl_r.dual)
                lamp = '{red: 1'b1, green: 1'b0};
            else
                lamp = '{red: 1'b1, green: 1'b1};
        end
    end

    // stream resync: accept a level only once it is stable
    // pulses no longer than the stable count are dropped as jitter
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            man_cand_r <= 1'b0;
            man_cnt_r <= '0;
            man_q_r <= 1'b0;
        end else if (MAN_STREAM_IN != man_cand_r) begin
            man_cand_r <= MAN_STREAM_IN;
            man_cnt_r <= '0;
        end else if (man_cnt_r != MAN_LAST) begin
            man_cnt_r <= man_cnt_r + MW'(1);
        end else begin
            man_q_r <= man_cand_r;
        end
    end

    // telegram error holds the stream active for a long stretch
    // a long active stretch cannot decode as a valid pulse sequence
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST)
            dist_cnt_r <= '0;
        else if (TELEGRAM_ERROR)
            dist_cnt_r <= DIST_LOAD;
        else if (dist_cnt_r != '0)
            dist_cnt_r <= dist_cnt_r - DW'(1);
    end

    // forwarded stream with polarity from the data inputs
    wire stream = man_q_r | (dist_cnt_r != '0);
    wire man_inv = DATA_INPUT_TWO ^ DATA_INPUT_THREE;
    wire man_lvl = stream ^ man_inv;

    // pin levels, one means released
    // the addressing channel wins over every status pattern on the first indicator
    wire ind2_en = ctrl_r.ext | ctrl_r.dual;
    wire ind1_slave = ADDR_CH_ACTIVE ? ADDR_CH_TX : ~lamp.red;
    wire ind2_off = ~ind2_en | (ADDR_CH_ACTIVE & ctrl_r.dual);
    wire ind2_slave = ind2_off | ~lamp.green;
    wire ind1_lvl = is_slave ? ind1_slave : man_lvl;
    wire ind2_lvl = is_slave ? ind2_slave : 1'b1;

    // open-drain drivers pull low when the level is zero
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ind1_oe_r <= 1'b0;
            ind2_oe_r <= 1'b0;
        end else begin
            ind1_oe_r <= ~ind1_lvl;
            ind2_oe_r <= ~ind2_lvl;
        end
    end

    // outputs
    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PERIPHERY_FAULT_STATUS_BIT = flt_r;
    assign POWER_FAIL_PARAMETER_PIN = pf_r;
    assign EXCHANGE_BLOCK = xblk_r;
    assign FIRST_INDICATOR_DRIVE = 1'b0; // open drain only pulls low
    assign FIRST_INDICATOR_OE = ind1_oe_r;
    assign SECOND_INDICATOR_DRIVE = 1'b0;
    assign SECOND_INDICATOR_OE = ind2_oe_r;

endmodule : fisi_top

`default_nettype wire

/* sim/fisi_lamps.sv */
// fisi_lamps.sv: indicator lamps and pull-ups on the two open-drain pins.
// assumes: an enable high means the device sinks the pin.
`timescale 1ns/10ps
`default_nettype none
module fisi_lamps (
    // enables from the device
    input wire logic oe_red,
    input wire logic oe_green,
    // resolved pin levels
    output logic pin_red,
    output logic pin_green
);
    // a released pin floats to the pull-up level
    assign pin_red = oe_red ? 1'b0 : 1'b1;
    assign pin_green = oe_green ? 1'b0 : 1'b1;
endmodule : fisi_lamps
`default_nettype wire

/* sim/fisi_properties.sv */
// fisi_properties.sv: port timing checks for fisi_top.
// assumes: bound to every fisi_top; one clock, reset NRST low.
`timescale 1ns/10ps
`default_nettype none
module fisi_properties #(
    parameter int PF_QUAL_CYC = 35000
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // pins and status
    input wire logic FAULT_INDICATION_INPUT,
    input wire logic PF_COMPARATOR_LOW,
    input wire logic INIT_BUSY,
    input wire logic PARAM_WRITE_CALL,
    input wire logic PERIPHERY_FAULT_STATUS_BIT,
    input wire logic POWER_FAIL_PARAMETER_PIN,
    input wire logic EXCHANGE_BLOCK
);
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);
    int low_run_r;

    // consecutive cycles with the supply below the reference
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST)
            low_run_r <= 0;
        else
            low_run_r <= PF_COMPARATOR_LOW ? low_run_r + 1 : 0;
    end

    // bus answer and idle levels
    ready_timing_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("ready not a single cycle after setup");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error flag outside access");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data not zero when idle");
    // status pins
    xblk_clear_a: assert property (
        PARAM_WRITE_CALL |=> !EXCHANGE_BLOCK [*8])
        else $error("exchange block not cleared");
    pf_qual_a: assert property (
        $rose(POWER_FAIL_PARAMETER_PIN) |->
        $past(low_run_r, 2) >= PF_QUAL_CYC - 2)
        else $error("power fail before qualification");
    pf_drop_a: assert property (
        !PF_COMPARATOR_LOW || INIT_BUSY |-> ##[1:2] !POWER_FAIL_PARAMETER_PIN)
        else $error("power fail not dropped");
    pf_init_a: assert property ($rose(POWER_FAIL_PARAMETER_PIN) |->
        !($past(INIT_BUSY) && $past(INIT_BUSY, 2)))
        else $error("power fail during initialisation");
    flt_sync_a: assert property (
        (!PSEL && $stable(FAULT_INDICATION_INPUT)) [*5]
        |=> $stable(PERIPHERY_FAULT_STATUS_BIT))
        else $error("fault status moved without cause");
endmodule : fisi_properties

bind fisi_top fisi_properties #(.PF_QUAL_CYC(PF_QUAL_CYC)) u_props (
    .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .FAULT_INDICATION_INPUT(FAULT_INDICATION_INPUT),
    .PF_COMPARATOR_LOW(PF_COMPARATOR_LOW), .INIT_BUSY(INIT_BUSY),
    .PARAM_WRITE_CALL(PARAM_WRITE_CALL),
    .PERIPHERY_FAULT_STATUS_BIT(PERIPHERY_FAULT_STATUS_BIT),
    .POWER_FAIL_PARAMETER_PIN(POWER_FAIL_PARAMETER_PIN),
    .EXCHANGE_BLOCK(EXCHANGE_BLOCK)
);
`default_nettype wire

/* sim/fisi_test.sv */
// fisi_test.sv: directed bench for fisi_top over apb and its pins.
// assumes: fisi_lamps and the bound checker compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "fisi_map.svh"
module fisi_test
    import fisi_pkg::*;
();
    localparam int BH = 4;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, a;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic flt, pfl, stb_n, di2, di3, busy, pwc, noex, wdog, ach, atx;
    logic man, terr, st_flt, pf_pin, xblk, i1, o1, oe1, i2, o2, oe2;
    int n_errors = 0;
    int total_checks = 0;

    // design with short power fail and flash counts
    fisi_top #(.PF_QUAL_CYC(20), .BLINK_HALF_CYC(BH)) dut (
        .REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FAULT_INDICATION_INPUT(flt), .PF_COMPARATOR_LOW(pfl),
        .DATA_STROBE_N(stb_n), .DATA_INPUT_TWO(di2),
        .DATA_INPUT_THREE(di3), .INIT_BUSY(busy),
        .PARAM_WRITE_CALL(pwc), .COMM_NO_EXCHANGE(noex),
        .WDOG_RESET_SEEN(wdog), .ADDR_CH_ACTIVE(ach), .ADDR_CH_TX(atx),
        .MAN_STREAM_IN(man), .TELEGRAM_ERROR(terr),
        .PERIPHERY_FAULT_STATUS_BIT(st_flt),
        .POWER_FAIL_PARAMETER_PIN(pf_pin), .EXCHANGE_BLOCK(xblk),
        .FIRST_INDICATOR_PIN(i1), .FIRST_INDICATOR_DRIVE(o1),
        .FIRST_INDICATOR_OE(oe1), .SECOND_INDICATOR_PIN(i2),
        .SECOND_INDICATOR_DRIVE(o2), .SECOND_INDICATOR_OE(oe2)
    );
    // lamps and pull-ups
    fisi_lamps lamps (.oe_red(oe1), .oe_green(oe2), .pin_red(i1),
        .pin_green(i2));

    // 50 MHz reference clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // counts and reports one comparison
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // prints the counts and the verdict, then stops
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    // one apb transfer; a read is compared under a mask
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d, input logic [31:0] m);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 9; n++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (n == 9) begin
            n_errors++;
            conclude();
        end
        check(pslverr, ad > 8'h08);
        if (!w)
            check(prdata & m, d);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic cfg(input fisi_ctrl_s c);
        apb(1'b1, `FISI_OFS_CTRL, {27'h0, c}, 32'h0);
    endtask : cfg

    // red pin must show the opposite level half a flash period later
    task automatic flash(input logic inv2);
        a = oe1;
        cyc(BH);
        check(oe1, !a);
        check(oe2, inv2 ? a : 1'b0);
        check(o1, 1'b0);
        check(o2, 1'b0);
    endtask : flash

    // main sequence
    initial begin
        {nrst, psel, penable, pwrite, flt, pfl, di2, di3, busy} <= '0;
        {pwc, noex, wdog, ach, atx, man, terr, paddr, pwdata} <= '0;
        stb_n <= 1'b1;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        cyc(2);
        // reset values, read-only status, unmapped place
        apb(1'b0, `FISI_OFS_CTRL, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, `FISI_OFS_NODE, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, `FISI_OFS_STAT, 32'h28, 32'hFFFFFFFF);
        apb(1'b1, `FISI_OFS_STAT, 32'hFF, 32'h0);
        apb(1'b0, `FISI_OFS_STAT, 32'h28, 32'hFFFFFFFF);
        apb(1'b0, 8'h0C, 32'h0, 32'hFFFFFFFF);
        // parameter call lifts the block; normal shows green
        pwc <= 1'b1;
        cyc(1);
        pwc <= 1'b0;
        cyc(1);
        check(xblk, 1'b0);
        apb(1'b1, `FISI_OFS_NODE, 32'h5, 32'h0);
        for (int k = 0; k < 4; k++) begin
            cfg('{k[1], k[0], 1'b0, FISI_SLAVE});
            cyc(3);
            check(oe1, 1'b0);
            check(oe2, k != 0);
        end
        // no-exchange from monitor or watchdog, dual and separate lamps
        for (int k = 0; k < 4; k++) begin
            cfg('{!k[1], 1'b1, 1'b0, FISI_SLAVE});
            noex <= !k[0];
            wdog <= k[0];
            cyc(3);
            check(oe1, 1'b1);
            check(oe2, k[1]);
        end
        noex <= 1'b0;
        wdog <= 1'b0;
        // extended indication while awaiting an address
        apb(1'b1, `FISI_OFS_NODE, 32'h0, 32'h0);
        cfg('{1'b0, 1'b1, 1'b0, FISI_SLAVE});
        cyc(2);
        flash(1'b0);
        cfg('{1'b1, 1'b1, 1'b0, FISI_SLAVE});
        cyc(2);
        a = oe2;
        cyc(BH);
        check(oe1, 1'b1);
        check(oe2, !a);
        apb(1'b1, `FISI_OFS_NODE, 32'h5, 32'h0);
        // fault input at both polarities, dual lamp alternates
        for (int k = 0; k < 2; k++) begin
            flt <= k[0];
            cfg('{1'b1, 1'b0, k[0], FISI_SLAVE});
            cyc(5);
            check(st_flt, 1'b0);
            flt <= !k[0];
            cyc(2);
            check(st_flt, 1'b0);
            cyc(3);
            check(st_flt, 1'b1);
            flash(1'b1);
        end
        flt <= 1'b0;
        // strobe held low: quiet at 2150 cycles, serious after 2250
        cfg('{1'b1, 1'b0, 1'b0, FISI_SLAVE});
        stb_n <= 1'b0;
        cyc(2150);
        apb(1'b0, `FISI_OFS_STAT, 32'h0, 32'h4);
        cyc(100);
        apb(1'b0, `FISI_OFS_STAT, 32'h4, 32'h4);
        flash(1'b0);
        stb_n <= 1'b1;
        cyc(3);
        apb(1'b0, `FISI_OFS_STAT, 32'h0, 32'h4);
        // addressing channel takes the red pin, dual releases green
        ach <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            atx <= k[0];
            cyc(3);
            check(i1, k[0]);
            check(oe2, 1'b0);
        end
        ach <= 1'b0;
        // master, repeater, monitor: stream, green released, power fail
        for (int m = 1; m < 4; m++) begin
            cfg('{1'b0, 1'b0, 1'b0, fisi_mode_e'(m)});
            for (int k = 0; k < 8; k++) begin
                {man, di2, di3} <= k[2:0];
                cyc(6);
                check(i1, k[2] ^ k[1] ^ k[0]);
                check(oe2, 1'b0);
            end
            man <= 1'b0;
            cyc(6);
            man <= 1'b1;
            cyc(1);
            man <= 1'b0;
            for (int k = 0; k < 6; k++) begin
                cyc(1);
                check(i1, 1'b0);
            end
            pfl <= 1'b1;
            cyc(10);
            pfl <= 1'b0;
            cyc(1);
            pfl <= 1'b1;
            cyc(15);
            check(pf_pin, 1'b0);
            cyc(10);
            check(pf_pin, m != 2);
            busy <= 1'b1;
            cyc(3);
            check(pf_pin, 1'b0);
            busy <= 1'b0;
            pfl <= 1'b0;
            terr <= 1'b1;
            cyc(1);
            terr <= 1'b0;
            cyc(5);
            check(i1, 1'b1);
            cyc(2010);
        end
        conclude();
    end
endmodule : fisi_test
`default_nettype wire
